// >>> fmc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef FMC_DEFINES_SVH
`define FMC_DEFINES_SVH
`define FMC_CTRL_OFF 8'h00
`define FMC_PAGE_OFF 8'h04
`define FMC_ROW_OFF 8'h08
`define FMC_COL_OFF 8'h0C
`define FMC_DATA_OFF 8'h10
`define FMC_PGCTL_OFF 8'h14
`define FMC_STAT_OFF 8'h18
`define FMC_PROT_OFF 8'h1C
`define FMC_CTRL_RST 8'h88
`define FMC_WAIT_HI 7
`define FMC_WAIT_LO 5
`define FMC_MEMEN_BIT 3
`define FMC_INFO_BIT 7
`define FMC_ROWPGM_BIT 0
`define FMC_MASS_BIT 1
`define FMC_PGERASE_BIT 2
`define FMC_ST_DONE_BIT 0
`define FMC_ST_RTO_BIT 1
`define FMC_ST_PERR_BIT 2
`define FMC_ERASED 8'hFF
`define FMC_LAST_COL 8'hFF
`define FMC_CLK_NS 50
`define FMC_BYTE_PROG_NS 66000
`define FMC_ROW_BYTE_NS 41000
`define FMC_MASS_ERASE_MS 200
`define FMC_PAGE_ERASE_MS 10
`define FMC_ROW_TIMEOUT_MS 31
`define FMC_BYTE_PROG_CYC ((`FMC_BYTE_PROG_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_ROW_BYTE_CYC ((`FMC_ROW_BYTE_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS)
`define FMC_RESP_OK 2'b00
`define FMC_RESP_ERR 2'b10
`endif

// >>> fmc_pkg.sv
// state types of the flash controller
package fmc_pkg;
  typedef enum logic [1:0] {ENG_IDLE = 2'b00, ENG_PROG = 2'b01, ENG_ERASE = 2'b10} fmc_eng_t;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_RD = 2'b01, M_WR = 2'b10, M_PW = 2'b11} fmc_mst_t;
  typedef enum logic [2:0] {W_IDLE = 3'b000, W_TAKE = 3'b001, W_PROG = 3'b010,
    W_PW = 3'b011, W_RESP = 3'b100} fmc_wst_t;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_TAKE = 2'b01, R_WAIT = 2'b10,
    R_RESP = 2'b11} fmc_rst_t;
endpackage : fmc_pkg

// >>> fmc_ctrl.sv
// flash controller: cpu memory port, axi4-lite registers, program and erase engine
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fmc_defines.svh"
// Functional notes
// - main array is 128 pages of 8 rows of 256 bytes, indexed by page/row/column
// - separate 512-byte information page of two rows
// - eight 32 KB protection blocks; program or erase of a protected block refused
// - lowest block protection follows the write protect pin level
// - cpu memory reads and writes become array reads and program cycles
// - information page only through the indirect data register
// - every flash read gets wait states; software sets count and enable first
// - data register read returns byte at page/row/column address
// - each data register access advances the combined address by one
// - reads of non-conflicting areas continue while programming
// - single-byte data write stalls until self-timed program ends, 66 to 85 us
// - row programming only via data writes, enabled by row_program_enable
// - row mode holds high voltage to column 255, 41 to 52 us per byte
// - row time-out aborts row programming and sets an error flag
// - memory write programs one byte with stall, never row mode
// - erase sets bytes to FFh, self-timed without stalling unrelated work
// - erase completion sets a status bit
// - flash accesses during erase wait until erase finishes
// - mass erase clears main array, info page too when info_page_select set
// - page erase clears one main page or the information page
// - wait_state_count bits [7:5] give 0 to 7 waits, reset value four
// - memory_space_enable bit 3 gates memory access; register access stays
module fmc_ctrl import fmc_pkg::*; #(
  parameter int PAGES = 128,
  parameter int ROWS = 8,
  parameter int COLS = 256,
  parameter int INFO_BYTES = 512,
  parameter int MASS_ERASE_CYC = (`FMC_MASS_ERASE_MS * 1000000) / `FMC_CLK_NS,
  parameter int PAGE_ERASE_CYC = (`FMC_PAGE_ERASE_MS * 1000000) / `FMC_CLK_NS,
  parameter int ROW_TIMEOUT_CYC = (`FMC_ROW_TIMEOUT_MS * 1000000) / `FMC_CLK_NS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wp_n_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic mem_wait_o,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o,
  output logic flash_hv_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int MAIN_BYTES = PAGES * ROWS * COLS;
  localparam int ARR_BYTES = MAIN_BYTES + INFO_BYTES;
  localparam int PAGE_BYTES = ROWS * COLS;
  localparam logic [18:0] MAIN_LAST = 19'(MAIN_BYTES - 1);
  localparam logic [18:0] ARR_LAST = 19'(ARR_BYTES - 1);

  logic [7:0] arr_q [0:ARR_BYTES-1];
  logic [7:0] ctrl_q, page_q, col_q;
  logic [2:0] row_q;
  logic [7:1] prot_q;
  logic rowpgm_q, mass_req_q, page_req_q, done_q, rto_q, perr_q;
  fmc_eng_t eng_q;
  fmc_mst_t mst_q;
  fmc_wst_t wst_q;
  fmc_rst_t rst_q;
  logic [22:0] eng_cnt_q;
  logic [18:0] clr_q, clr_end_q, eng_addr_q;
  logic [7:0] eng_page_q;
  logic eng_done_q, eng_row_q, hv_q;
  logic [19:0] rto_cnt_q;
  logic [2:0] mcnt_q, rcnt_q;
  logic [7:0] wd_q, ra_q;
  logic [7:0] prot_vec;
  logic mem_go, axi_go, ers_go, rto_hit, io_inc, io_prot, mem_prot, arr_we;
  logic [18:0] io_addr, arr_wa;
  logic [7:0] arr_wd, reg_rd;

  // linear array index from page, row and column; info page follows the main array
  function automatic logic [18:0] lin_addr(input logic [7:0] pg, input logic [2:0] rw,
                                           input logic [7:0] cl);
    if (pg[`FMC_INFO_BIT])
      lin_addr = 19'(MAIN_BYTES) + {10'h000, rw[0], cl};
    else
      lin_addr = {1'b0, pg[6:0], rw, cl};
  endfunction : lin_addr

  // block protection of a linear index; info page has no block
  function automatic logic is_prot(input logic [18:0] a, input logic [7:0] pv);
    is_prot = (a <= MAIN_LAST) && pv[a[17:15]];
  endfunction : is_prot

  assign prot_vec = {prot_q, ~wp_n_i};
  assign io_addr = lin_addr(page_q, row_q, col_q);
  assign io_prot = is_prot(io_addr, prot_vec);
  assign mem_prot = is_prot({1'b0, mem_addr_i}, prot_vec);
  assign rto_hit = rowpgm_q && (rto_cnt_q == 20'(ROW_TIMEOUT_CYC - 1));
  // memory port has priority for the single engine
  assign mem_go = (mst_q == M_WR) && (eng_q == ENG_IDLE) && !mem_prot;
  assign axi_go = (wst_q == W_PROG) && (eng_q == ENG_IDLE) && !mem_go && !io_prot;
  assign ers_go = (mass_req_q || page_req_q) && (eng_q == ENG_IDLE) && !mem_go
                  && !(wst_q == W_PROG);
  assign io_inc = ((wst_q == W_PROG) && (eng_q == ENG_IDLE) && !mem_go)
                  || ((rst_q == R_WAIT) && (eng_q != ENG_ERASE) && (rcnt_q == 3'h0)
                  && !((eng_q == ENG_PROG) && (eng_page_q == page_q)));

  // array write port: program ANDs data in, erase walks FFh
  always_comb begin
    arr_we = 1'b0;
    arr_wa = clr_q;
    arr_wd = `FMC_ERASED;
    if (eng_q == ENG_ERASE && clr_q <= clr_end_q) begin
      arr_we = 1'b1;
    end else if (mem_go) begin
      arr_we = 1'b1;
      arr_wa = {1'b0, mem_addr_i};
      arr_wd = arr_q[{1'b0, mem_addr_i}] & mem_wdata_i;
    end else if (axi_go) begin
      arr_we = 1'b1;
      arr_wa = io_addr;
      arr_wd = arr_q[io_addr] & wd_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (arr_we) begin
      arr_q[arr_wa] <= arr_wd;
    end
  end

  // program and erase engine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      eng_q <= ENG_IDLE;
      eng_cnt_q <= 23'h000000;
      clr_q <= 19'h00000;
      clr_end_q <= 19'h00000;
      eng_addr_q <= 19'h00000;
      eng_page_q <= 8'h00;
      eng_row_q <= 1'b0;
      eng_done_q <= 1'b0;
    end else begin
      eng_done_q <= 1'b0;
      case (eng_q)
        ENG_IDLE: begin
          if (mem_go || axi_go) begin
            eng_q <= ENG_PROG;
            eng_addr_q <= arr_wa;
            eng_page_q <= mem_go ? {1'b0, mem_addr_i[17:11]} : page_q;
            eng_row_q <= axi_go && rowpgm_q;
            eng_cnt_q <= (axi_go && rowpgm_q) ? 23'(`FMC_ROW_BYTE_CYC - 1)
                                              : 23'(`FMC_BYTE_PROG_CYC - 1);
          end else if (ers_go && mass_req_q && prot_vec == 8'h00) begin
            eng_q <= ENG_ERASE;
            clr_q <= 19'h00000;
            clr_end_q <= page_q[`FMC_INFO_BIT] ? ARR_LAST : MAIN_LAST;
            eng_cnt_q <= 23'(MASS_ERASE_CYC - 1);
          end else if (ers_go && page_req_q && !is_prot(io_addr, prot_vec)) begin
            eng_q <= ENG_ERASE;
            clr_q <= page_q[`FMC_INFO_BIT] ? 19'(MAIN_BYTES) : {1'b0, page_q[6:0], 11'h000};
            clr_end_q <= page_q[`FMC_INFO_BIT] ? ARR_LAST
                         : {1'b0, page_q[6:0], 11'h000} + 19'(PAGE_BYTES - 1);
            eng_cnt_q <= 23'(PAGE_ERASE_CYC - 1);
          end
        end
        ENG_PROG: begin
          if (eng_cnt_q == 23'h000000 || (eng_row_q && rto_hit)) begin
            eng_q <= ENG_IDLE;
            eng_done_q <= 1'b1;
          end else begin
            eng_cnt_q <= eng_cnt_q - 23'h000001;
          end
        end
        ENG_ERASE: begin
          if (clr_q <= clr_end_q) begin
            clr_q <= clr_q + 19'h00001;
          end
          if (eng_cnt_q != 23'h000000) begin
            eng_cnt_q <= eng_cnt_q - 23'h000001;
          end else if (clr_q > clr_end_q) begin
            eng_q <= ENG_IDLE;
            eng_done_q <= 1'b1;
          end
        end
        default: eng_q <= ENG_IDLE;
      endcase
    end
  end

  // high voltage stays on for the whole row in row mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hv_q <= 1'b0;
      rto_cnt_q <= 20'h00000;
    end else begin
      hv_q <= rowpgm_q || (eng_q != ENG_IDLE);
      rto_cnt_q <= rowpgm_q ? rto_cnt_q + 20'h00001 : 20'h00000;
    end
  end
  assign flash_hv_o = hv_q;

  // cpu memory port
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mst_q <= M_IDLE;
      mcnt_q <= 3'h0;
      mem_wait_o <= 1'b0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 8'h00;
    end else begin
      mem_ack_o <= 1'b0;
      case (mst_q)
        M_IDLE: begin
          if (mem_req_i && !mem_ack_o) begin
            mem_wait_o <= 1'b1;
            mcnt_q <= ctrl_q[`FMC_WAIT_HI:`FMC_WAIT_LO];
            if (!ctrl_q[`FMC_MEMEN_BIT]) begin
              mst_q <= M_PW;
            end else begin
              mst_q <= mem_we_i ? M_WR : M_RD;
            end
          end
        end
        M_RD: begin
          if (eng_q == ENG_ERASE) begin
            mcnt_q <= mcnt_q;
          end else if (eng_q == ENG_PROG && eng_page_q == {1'b0, mem_addr_i[17:11]}) begin
            mcnt_q <= mcnt_q;
          end else if (mcnt_q != 3'h0) begin
            mcnt_q <= mcnt_q - 3'h1;
          end else begin
            mem_rdata_o <= arr_q[{1'b0, mem_addr_i}];
            mem_ack_o <= 1'b1;
            mem_wait_o <= 1'b0;
            mst_q <= M_IDLE;
          end
        end
        M_WR: begin
          if (eng_q == ENG_IDLE) begin
            mst_q <= mem_prot ? M_IDLE : M_PW;
            mem_ack_o <= mem_prot;
            mem_wait_o <= !mem_prot;
          end
        end
        M_PW: begin
          if (!ctrl_q[`FMC_MEMEN_BIT] && eng_q != ENG_PROG) begin
            mem_rdata_o <= `FMC_ERASED;
            mem_ack_o <= 1'b1;
            mem_wait_o <= 1'b0;
            mst_q <= M_IDLE;
          end else if (eng_done_q) begin
            mem_ack_o <= 1'b1;
            mem_wait_o <= 1'b0;
            mst_q <= M_IDLE;
          end
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // register file
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `FMC_CTRL_RST;
      page_q <= 8'h00;
      row_q <= 3'h0;
      col_q <= 8'h00;
      prot_q <= 7'h00;
      rowpgm_q <= 1'b0;
      mass_req_q <= 1'b0;
      page_req_q <= 1'b0;
      done_q <= 1'b0;
      rto_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      if (wst_q == W_TAKE && s_axi_wstrb[0]) begin
        case (s_axi_awaddr)
          `FMC_CTRL_OFF: ctrl_q <= s_axi_wdata[7:0] & 8'hE8;
          `FMC_PAGE_OFF: page_q <= s_axi_wdata[7:0];
          `FMC_ROW_OFF: row_q <= s_axi_wdata[2:0];
          `FMC_COL_OFF: col_q <= s_axi_wdata[7:0];
          `FMC_PROT_OFF: prot_q <= s_axi_wdata[7:1];
          `FMC_PGCTL_OFF: begin
            if (eng_q != ENG_ERASE && !mass_req_q && !page_req_q) begin
              rowpgm_q <= s_axi_wdata[`FMC_ROWPGM_BIT];
              mass_req_q <= s_axi_wdata[`FMC_MASS_BIT] && !rowpgm_q;
              page_req_q <= s_axi_wdata[`FMC_PGERASE_BIT] && !rowpgm_q;
            end
          end
          default: ctrl_q <= ctrl_q;
        endcase
      end
      if (io_inc) begin
        {page_q[6:0], row_q, col_q} <= {page_q[6:0], row_q, col_q} + 18'h00001;
      end
      if (ers_go) begin
        mass_req_q <= 1'b0;
        page_req_q <= 1'b0;
      end
      if (eng_done_q && eng_row_q && eng_addr_q[7:0] == `FMC_LAST_COL) begin
        rowpgm_q <= 1'b0;
      end
      if (rto_hit) begin
        rowpgm_q <= 1'b0;
      end
      if (wst_q == W_TAKE && s_axi_awaddr == `FMC_STAT_OFF && s_axi_wstrb[0]) begin
        done_q <= done_q & ~s_axi_wdata[`FMC_ST_DONE_BIT];
        rto_q <= rto_q & ~s_axi_wdata[`FMC_ST_RTO_BIT];
        perr_q <= perr_q & ~s_axi_wdata[`FMC_ST_PERR_BIT];
      end
      if (eng_q == ENG_ERASE && eng_cnt_q == 23'h000000 && clr_q > clr_end_q) begin
        done_q <= 1'b1;
      end
      if (rto_hit) begin
        rto_q <= 1'b1;
      end
      if ((ers_go && !(eng_q == ENG_IDLE && (mass_req_q ? prot_vec == 8'h00
          : !is_prot(io_addr, prot_vec)))) || ((mst_q == M_WR) && (eng_q == ENG_IDLE)
          && mem_prot) || ((wst_q == W_PROG) && (eng_q == ENG_IDLE) && !mem_go && io_prot)) begin
        perr_q <= 1'b1;
      end
    end
  end

  // register read mux
  always_comb begin
    case (ra_q)
      `FMC_CTRL_OFF: reg_rd = ctrl_q;
      `FMC_PAGE_OFF: reg_rd = page_q;
      `FMC_ROW_OFF: reg_rd = {5'h00, row_q};
      `FMC_COL_OFF: reg_rd = col_q;
      `FMC_PGCTL_OFF: reg_rd = {5'h00, page_req_q || (eng_q == ENG_ERASE),
                                mass_req_q || (eng_q == ENG_ERASE), rowpgm_q};
      `FMC_STAT_OFF: reg_rd = {5'h00, perr_q, rto_q, done_q};
      `FMC_PROT_OFF: reg_rd = prot_vec;
      default: reg_rd = 8'h00;
    endcase
  end

  // axi4-lite write channel
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wst_q <= W_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FMC_RESP_OK;
      wd_q <= 8'h00;
    end else begin
      case (wst_q)
        W_IDLE: begin
          if (s_axi_awvalid && s_axi_wvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wst_q <= W_TAKE;
          end
        end
        W_TAKE: begin
          s_axi_awready <= 1'b0;
          s_axi_wready <= 1'b0;
          wd_q <= s_axi_wdata[7:0];
          s_axi_bresp <= (s_axi_awaddr[1:0] != 2'b00 || s_axi_awaddr > `FMC_PROT_OFF)
                         ? `FMC_RESP_ERR : `FMC_RESP_OK;
          if (s_axi_awaddr == `FMC_DATA_OFF && s_axi_wstrb[0]) begin
            wst_q <= W_PROG;
          end else begin
            s_axi_bvalid <= 1'b1;
            wst_q <= W_RESP;
          end
        end
        W_PROG: begin
          if (eng_q == ENG_IDLE && !mem_go) begin
            wst_q <= io_prot ? W_RESP : W_PW;
            s_axi_bvalid <= io_prot;
          end
        end
        W_PW: begin
          if (eng_done_q) begin
            s_axi_bvalid <= 1'b1;
            wst_q <= W_RESP;
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_q <= W_IDLE;
          end
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  // axi4-lite read channel
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_q <= R_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FMC_RESP_OK;
      ra_q <= 8'h00;
      rcnt_q <= 3'h0;
    end else begin
      case (rst_q)
        R_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            rst_q <= R_TAKE;
          end
        end
        R_TAKE: begin
          s_axi_arready <= 1'b0;
          ra_q <= s_axi_araddr;
          rcnt_q <= ctrl_q[`FMC_WAIT_HI:`FMC_WAIT_LO];
          s_axi_rresp <= (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > `FMC_PROT_OFF)
                         ? `FMC_RESP_ERR : `FMC_RESP_OK;
          rst_q <= (s_axi_araddr == `FMC_DATA_OFF) ? R_WAIT : R_RESP;
        end
        R_WAIT: begin
          if (eng_q == ENG_ERASE || (eng_q == ENG_PROG && eng_page_q == page_q)) begin
            rcnt_q <= rcnt_q;
          end else if (rcnt_q != 3'h0) begin
            rcnt_q <= rcnt_q - 3'h1;
          end else begin
            s_axi_rdata <= {24'h000000, arr_q[io_addr]};
            s_axi_rvalid <= 1'b1;
            rst_q <= R_RESP;
          end
        end
        R_RESP: begin
          if (ra_q != `FMC_DATA_OFF && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, reg_rd};
          end
          if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_q <= R_IDLE;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end
endmodule : fmc_ctrl

// >>> fmc_ctrl_monitor.sv
// port assertions for the flash controller
`timescale 1ns/1ps
module fmc_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wp_n_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic mem_wait_o,
  input wire logic mem_ack_o,
  input wire logic [7:0] mem_rdata_o,
  input wire logic flash_hv_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] ctrl_q;
  int lat_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // shadow of the control register and cycles of the current cpu access
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h88;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00) begin
      ctrl_q <= s_axi_wdata[7:0];
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_q <= 0;
    end else begin
      lat_q <= mem_req_i ? lat_q + 1 : 0;
    end
  end
  sequence s_take;
    mem_req_i && !mem_wait_o && !mem_ack_o;
  endsequence
  sequence s_done;
    mem_ack_o && lat_q > 4;
  endsequence
  a_read_waits: assert property (s_take ##0 !mem_we_i |=> !mem_ack_o)
    else $error("read answered without wait");
  a_read_count: assert property (mem_ack_o && !mem_we_i && ctrl_q[3]
    |-> lat_q > ctrl_q[7:5])
    else $error("read shorter than wait count");
  a_off_reads: assert property (mem_ack_o && !mem_we_i && !ctrl_q[3]
    |-> mem_rdata_o == 8'hFF)
    else $error("disabled read returned data");
  a_ack_single: assert property (mem_ack_o |=> !mem_ack_o && !mem_wait_o)
    else $error("ack not a single cycle");
  a_prog_time: assert property (s_done ##0 mem_we_i |-> lat_q >= 1320)
    else $error("program shorter than byte time");
  a_write_hv: assert property ((mem_req_i && mem_we_i && mem_wait_o) [*4]
    |-> flash_hv_o)
    else $error("stalled write without high voltage");
  a_boot_guard: assert property (mem_ack_o && mem_we_i && !wp_n_i
    && mem_addr_i < 18'h08000 |-> lat_q <= 4)
    else $error("protected write was programmed");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
endmodule : fmc_ctrl_monitor

bind fmc_ctrl fmc_ctrl_monitor i_fmc_ctrl_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .wp_n_i(wp_n_i), .mem_req_i(mem_req_i), .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i),
  .mem_wait_o(mem_wait_o), .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o),
  .flash_hv_o(flash_hv_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> fmc_cpu_model.sv
// behavioural cpu issuing flash memory cycles
`timescale 1ns/1ps
module fmc_cpu_model (
  input wire logic clk_i,
  output logic req_o,
  output logic we_o,
  output logic [17:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 18'h0;
    wdata_o = 8'h0;
  end
  // one access after an idle gap; released lines are scrambled
  task automatic access(input int gap, input logic we, input logic [17:0] a,
    input logic [7:0] d, output logic [7:0] q, output int lat);
    repeat (gap + 1) @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    addr_o <= a;
    wdata_o <= d;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (ack_i !== 1'b1);
    q = rdata_i;
    req_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : access
endmodule : fmc_cpu_model

// >>> fmc_ctrl_tb_top.sv
// self-checking bench for the flash controller
`timescale 1ns/1ps
module fmc_ctrl_tb_top;
  logic mclk_i, rst_i, wp_n_i, mem_req_i, mem_we_i, mem_wait_o, mem_ack_o, flash_hv_o;
  logic [17:0] mem_addr_i;
  logic [7:0] mem_wdata_i, mem_rdata_o, s_axi_awaddr, s_axi_araddr, v, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [31:0] seed = 32'h2545;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] fl [int];
  int error_cnt, n_tests, lat, a, tno;
  fmc_ctrl #(.PAGE_ERASE_CYC(2048), .MASS_ERASE_CYC(262656), .ROW_TIMEOUT_CYC(5000)) i_fmc_ctrl (
    .mclk_i(mclk_i), .rst_i(rst_i), .wp_n_i(wp_n_i), .mem_req_i(mem_req_i),
    .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
    .mem_wait_o(mem_wait_o), .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o),
    .flash_hv_o(flash_hv_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  fmc_cpu_model i_fmc_cpu_model (.clk_i(mclk_i), .req_o(mem_req_i), .we_o(mem_we_i),
    .addr_o(mem_addr_i), .wdata_o(mem_wdata_i), .ack_i(mem_ack_o), .rdata_i(mem_rdata_o));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] ad, input logic [7:0] dd);
    @(posedge mclk_i);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, dd};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [7:0] q);
    @(posedge mclk_i);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    axr(ad, v);
    chk(v, e);
  endtask : rchk
  task automatic setp(input logic [7:0] p, input logic [7:0] r, input logic [7:0] c);
    axw(8'h04, p);
    axw(8'h08, r);
    axw(8'h0C, c);
  endtask : setp
  task automatic cpu(input logic we, input int ad, input logic [7:0] dd);
    i_fmc_cpu_model.access(int'(rnd() % 3), we, ad[17:0], dd, v, lat);
  endtask : cpu
  task automatic erase(input int base, input int n);
    for (int k = 0; k < n; k++) fl[base + k] = 8'hFF;
  endtask : erase
  task automatic tend();
    $display("test %0d done", tno);
    tno++;
  endtask : tend
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    wp_n_i = 1'b1;
    rst_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(8'h00, 8'h88);
    rchk(8'h1C, 8'h00);
    axr(8'h22, v);
    chk({6'h0, resp}, 8'h02);
    chk(v, 8'h00);
    s_axi_wstrb <= 4'hE;
    axw(8'h08, 8'h05);
    rchk(8'h08, 8'h00);
    s_axi_wstrb <= 4'hF;
    tend();
    setp(8'h01, 8'h00, 8'h00);
    axw(8'h14, 8'h04);
    erase(32'h800, 2048);
    cpu(1'b0, 32'h9A5, 8'h00);
    chk(v, 8'hFF);
    chk({7'h0, lat > 1900}, 8'h01);
    rchk(8'h18, 8'h01);
    axw(8'h18, 8'h01);
    for (int w = 0; w < 8; w++) begin
      axw(8'h00, {w[2:0], 5'h08});
      rchk(8'h00, {w[2:0], 5'h08});
      cpu(1'b0, 32'h800 + w, 8'h00);
      chk(v, 8'hFF);
      chk({7'h0, lat >= w + 1}, 8'h01);
    end
    axw(8'h00, 8'h88);
    a = 32'h800 + int'(rnd() % 1536);
    d = 8'(rnd());
    cpu(1'b1, a, d);
    fl[a] = fl[a] & d;
    cpu(1'b0, a, 8'h00);
    chk(v, fl[a]);
    tend();
    setp(8'h01, 8'h07, 8'hFE);
    axw(8'h10, d);
    axw(8'h10, ~d);
    fl[32'hFFE] = d;
    fl[32'hFFF] = ~d;
    rchk(8'h04, 8'h02);
    rchk(8'h08, 8'h00);
    rchk(8'h0C, 8'h00);
    setp(8'h01, 8'h07, 8'hFE);
    rchk(8'h10, fl[32'hFFE]);
    rchk(8'h10, fl[32'hFFF]);
    setp(8'h80, 8'h01, 8'hFE);
    axw(8'h14, 8'h04);
    do axr(8'h18, v); while (v[0] !== 1'b1);
    axw(8'h18, 8'h01);
    erase(32'h40000, 512);
    axw(8'h10, 8'hFF);
    axw(8'h10, d);
    fl[32'h401FF] = d;
    setp(8'h80, 8'h01, 8'hFE);
    rchk(8'h10, 8'hFF);
    rchk(8'h10, fl[32'h401FF]);
    cpu(1'b0, a, 8'h00);
    chk(v, fl[a]);
    tend();
    wp_n_i <= 1'b0;
    rchk(8'h1C, 8'h01);
    cpu(1'b1, 32'h10, 8'h00);
    rchk(8'h18, 8'h04);
    axw(8'h18, 8'h04);
    setp(8'h01, 8'h00, 8'h00);
    axw(8'h14, 8'h04);
    rchk(8'h18, 8'h04);
    axw(8'h18, 8'h04);
    axw(8'h14, 8'h02);
    rchk(8'h18, 8'h04);
    axw(8'h18, 8'h04);
    cpu(1'b0, a, 8'h00);
    chk(v, fl[a]);
    wp_n_i <= 1'b1;
    axw(8'h1C, 8'h02);
    cpu(1'b1, 32'h8000, 8'h00);
    rchk(8'h18, 8'h04);
    axw(8'h18, 8'h04);
    axw(8'h1C, 8'h00);
    tend();
    axw(8'h00, 8'h80);
    cpu(1'b0, a, 8'h00);
    chk(v, 8'hFF);
    setp(8'h01, 8'h07, 8'hFE);
    rchk(8'h10, fl[32'hFFE]);
    axw(8'h00, 8'h88);
    setp(8'h01, 8'h06, 8'h00);
    axw(8'h14, 8'h01);
    rchk(8'h14, 8'h01);
    axw(8'h10, ~d);
    fl[32'hE00] = ~d;
    chk({7'h0, flash_hv_o}, 8'h01);
    repeat (5200) @(posedge mclk_i);
    rchk(8'h18, 8'h02);
    rchk(8'h14, 8'h00);
    chk({7'h0, flash_hv_o}, 8'h00);
    setp(8'h01, 8'h06, 8'h00);
    rchk(8'h10, fl[32'hE00]);
    tend();
    give_verdict();
  end
endmodule : fmc_ctrl_tb_top
